// [bench/iocm_top_test.sv]
// Purpose: Self-checking bench for oscillator control, divider and multiplier
// Assumes: Inputs change at the falling edge, outputs are sampled there too
// Notes:   Tick rates come from trims, so rate counts allow a little slack
module iocm_top_test;
   timeunit 1ns;
   timeprecision 1ns;

   logic       clk_i, srst_i, ce_i, sfr_wr_i, cmp0_en_i, cmp0_out_i, ext_osc_i;
   logic       osc_tick_o, system_clock_tick_o;
   logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, rv;
   logic [3:0] port_match_i;
   int         err_total, compares, o, s, n;

   iocm_top #(
      .FACTORY_COARSE (7'h55),
      .FACTORY_FINE   (6'h2a)
   ) uut (
      .clk_i         (clk_i),
      .srst_i        (srst_i),
      .ce_i          (ce_i),
      .sfr_addr_i    (sfr_addr_i),
      .sfr_wr_i      (sfr_wr_i),
      .sfr_wdata_i   (sfr_wdata_i),
      .sfr_rdata_o   (sfr_rdata_o),
      .port_match_i  (port_match_i),
      .cmp0_en_i     (cmp0_en_i),
      .cmp0_out_i    (cmp0_out_i),
      .ext_osc_i     (ext_osc_i),
      .osc_tick_o    (osc_tick_o),
      .system_clock_tick_o (system_clock_tick_o)
   );

   // 10 MHz block clock
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   // External source runs from time zero, so it is stable before any bring-up
   initial begin
      ext_osc_i = 1'b0;
      forever #800 ext_osc_i = ~ext_osc_i;
   end

   // Comparison helpers, each counts and reports its own mismatch
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic near(input int got, input int exp, input int tol, input string what);
      compares++;
      if (got < exp - tol || got > exp + tol) begin
         err_total++;
         $display("CHECK FAILED at %0t: %s count %0d expected %0d", $time, what, got, exp);
      end
   endtask

   // Register port: one-cycle write strobe, read data one clock after address
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      sfr_addr_i  = a;
      sfr_wdata_i = d;
      sfr_wr_i    = 1'b1;
      @(negedge clk_i);
      sfr_wr_i    = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_i);
      sfr_addr_i = a;
      @(negedge clk_i);
      d = sfr_rdata_o;
   endtask

   // Count ticks of both outputs over a fixed span
   task automatic count(input int cyc, output int oc, output int sc);
      oc = 0;
      sc = 0;
      repeat (cyc) begin
         @(negedge clk_i);
         oc += (osc_tick_o === 1'b1);
         sc += (system_clock_tick_o === 1'b1);
      end
   endtask

   // Wait for the next system tick, counting oscillator ticks; bounded
   task automatic wait_sys(output int oc);
      int i;
      i  = 0;
      oc = 0;
      do begin
         @(negedge clk_i);
         oc += (osc_tick_o === 1'b1);
         i++;
      end while (system_clock_tick_o !== 1'b1 && i < 4000);
      near(i < 4000, 1, 0, "system tick wait");
   endtask

   task automatic t_reset();
      rd(iocm_pkg::ADDR_CTRL, rv);
      chk(rv, iocm_pkg::CTRL_RESET, "control reset");
      rd(iocm_pkg::ADDR_COARSE, rv);
      chk(rv, 8'h55, "coarse reset");
      rd(iocm_pkg::ADDR_FINE, rv);
      chk(rv, 8'h2a, "fine reset");
      $display("Test reset done");
   endtask

   // Read-only and unused bits ignore writes; unmapped reads give zero
   task automatic t_regs();
      wr(iocm_pkg::ADDR_CTRL, 8'hd7);
      rd(iocm_pkg::ADDR_CTRL, rv);
      chk(rv, 8'hd7, "reserved bit");
      wr(iocm_pkg::ADDR_COARSE, 8'hff);
      rd(iocm_pkg::ADDR_COARSE, rv);
      chk(rv, 8'h7f, "coarse unused bit");
      wr(iocm_pkg::ADDR_FINE, 8'hff);
      rd(iocm_pkg::ADDR_FINE, rv);
      chk(rv, 8'h3f, "fine unused bits");
      wr(8'h50, 8'hff);
      rd(8'h50, rv);
      chk(rv, 8'h00, "unmapped read");
      $display("Test registers done");
   endtask

   // Each code: first full period after the switch has the new length
   task automatic t_divider();
      for (int c = 0; c < 8; c++) begin
         wr(iocm_pkg::ADDR_CTRL, {5'b11000, c[2:0]});
         wait_sys(n);
         wait_sys(n);
         near(n, 1 << (7 - c), 0, "divider period");
      end
      $display("Test divider done");
   endtask

   // Larger trim runs faster; fine trim nudges the rate
   task automatic t_trim();
      logic [7:0] tc[4] = '{8'h7f, 8'h7f, 8'h3f, 8'h1f};
      logic [7:0] tf[4] = '{8'h3f, 8'h1f, 8'h3f, 8'h3f};
      int         te[4] = '{512, 510, 256, 128};
      for (int i = 0; i < 4; i++) begin
         wr(iocm_pkg::ADDR_COARSE, tc[i]);
         wr(iocm_pkg::ADDR_FINE, tf[i]);
         count(1024, o, s);
         near(o, te[i], 1, "trim rate");
      end
      $display("Test trim done");
   endtask

   // Off and reserved enable codes stop ticks; ready returns after start
   task automatic t_enable();
      for (int e = 0; e < 3; e++) begin
         wr(iocm_pkg::ADDR_CTRL, {e[1:0], 6'h07});
         count(64, o, s);
         near(o, 0, 0, "disabled ticks");
         rd(iocm_pkg::ADDR_CTRL, rv);
         chk(rv, {e[1:0], 6'h07}, "disabled ready");
      end
      wr(iocm_pkg::ADDR_CTRL, 8'hc7);
      rd(iocm_pkg::ADDR_CTRL, rv);
      chk(rv, 8'hc7, "ready while starting");
      count(64, o, s);
      near(o, 8, 1, "enabled ticks");
      rd(iocm_pkg::ADDR_CTRL, rv);
      chk(rv, 8'hd7, "ready after start");
      // Clock enable low freezes all state, so no tick may leave
      ce_i = 1'b0;
      count(64, o, s);
      ce_i = 1'b1;
      near(o + s, 0, 0, "frozen ticks");
      $display("Test enable done");
   endtask

   // Suspend, then wake by each port match and by the comparator
   task automatic t_suspend();
      // Comparator low while disabled must leave the oscillator asleep
      wr(iocm_pkg::ADDR_CTRL, 8'he7);
      cmp0_en_i  = 1'b0;
      cmp0_out_i = 1'b0;
      repeat (8) @(negedge clk_i);
      rd(iocm_pkg::ADDR_CTRL, rv);
      chk(rv, 8'he7, "disabled comparator wake");
      cmp0_out_i = 1'b1;
      repeat (4) @(negedge clk_i);
      cmp0_en_i  = 1'b1;
      for (int k = 0; k < 5; k++) begin
         wr(iocm_pkg::ADDR_CTRL, 8'he7);
         count(32, o, s);
         near(o, 0, 0, "suspended ticks");
         rd(iocm_pkg::ADDR_CTRL, rv);
         chk(rv, 8'he7, "suspended state");
         @(negedge clk_i);
         if (k < 4) port_match_i = 4'h1 << k;
         else cmp0_out_i = 1'b0;
         @(negedge clk_i);
         port_match_i = 4'h0;
         repeat (4) @(negedge clk_i);
         cmp0_out_i = 1'b1;
         count(64, o, s);
         near(o, 8, 2, "ticks after wake");
         rd(iocm_pkg::ADDR_CTRL, rv);
         chk(rv, 8'hd7, "suspend cleared");
      end
      $display("Test suspend done");
   endtask

   // Software bring-up order: clear, configure, enable, wait, initialise, poll
   task automatic mult_up(input logic [1:0] sel, input logic [2:0] sc);
      int i;
      wr(iocm_pkg::ADDR_MULT, 8'h00);
      wr(iocm_pkg::ADDR_MULT, {3'b000, sc, sel});
      wr(iocm_pkg::ADDR_MULT, {3'b100, sc, sel});
      repeat (60) @(negedge clk_i);
      wr(iocm_pkg::ADDR_MULT, {3'b110, sc, sel});
      i = 0;
      do begin
         rd(iocm_pkg::ADDR_MULT, rv);
         i++;
      end while (rv[iocm_pkg::MULT_RDY] !== 1'b1 && i < 200);
      chk(rv, {3'b111, sc, sel}, "multiplier ready");
   endtask

   // Rate for every scale on the halved internal input, then other inputs
   task automatic t_mult();
      int k, r;
      wr(iocm_pkg::ADDR_SRC, {6'h00, iocm_pkg::SRC_MULT});
      for (int i = 0; i < 10; i++) begin
         logic [1:0] sel;
         logic [2:0] sc;
         sel = (i < 8) ? iocm_pkg::MSEL_INT2 : (i == 8 ? iocm_pkg::MSEL_EXT : iocm_pkg::MSEL_EXT2);
         sc  = (i < 8) ? i[2:0] : 3'h0;
         k   = (sc < 2) ? 2 : (sc == 7 ? 7 : sc + 1);
         mult_up(sel, sc);
         count(64, o, s);
         count(1024, o, s);
         r   = (sel == iocm_pkg::MSEL_EXT2) ? 256 : 512;
         near(s, r / k, 3, "multiplier rate");
      end
      $display("Test multiplier done");
   endtask

   // Slow input: four ticks on alternate cycles, then idle
   task automatic t_burst();
      int idle;
      int i;
      mult_up(iocm_pkg::MSEL_INT2, 3'h0);
      idle = 0;
      i    = 0;
      do begin
         @(negedge clk_i);
         i++;
         idle = (system_clock_tick_o === 1'b1) ? idle : idle + 1;
         if (system_clock_tick_o === 1'b1 && idle < 3) idle = 0;
      end while (!(system_clock_tick_o === 1'b1 && idle >= 3) && i < 500);
      for (int j = 0; j < 8; j++) begin
         @(negedge clk_i);
         rv[j] = system_clock_tick_o;
      end
      chk(rv, 8'h2a, "burst pattern");
      $display("Test burst done");
   endtask

   // Reserved source gives no ticks; external source passes its edges
   task automatic t_source();
      wr(iocm_pkg::ADDR_SRC, 8'h03);
      count(256, o, s);
      near(s, 0, 0, "reserved source");
      wr(iocm_pkg::ADDR_SRC, {6'h00, iocm_pkg::SRC_EXT});
      count(1024, o, s);
      near(s, 64, 2, "external source");
      $display("Test source done");
   endtask

   // Verdict and end of run
   task automatic conclude();
      $display("Counts: %0d compares, %0d mismatches", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Watchdog, well beyond the expected run of some 20000 cycles
   initial begin
      repeat (90000) @(posedge clk_i);
      err_total++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      conclude();
   end

   // Main sequence
   initial begin
      err_total    = 0;
      compares     = 0;
      srst_i       = 1'b1;
      ce_i         = 1'b1;
      sfr_addr_i   = 8'h00;
      sfr_wr_i     = 1'b0;
      sfr_wdata_i  = 8'h00;
      port_match_i = 4'h0;
      cmp0_en_i    = 1'b1;
      cmp0_out_i   = 1'b1;
      repeat (5) @(negedge clk_i);
      srst_i = 1'b0;
      t_reset();
      t_regs();
      t_divider();
      t_trim();
      t_enable();
      t_suspend();
      t_mult();
      t_burst();
      t_source();
      conclude();
   end
endmodule

// [hw/iocm_mul_if.sv]
// Purpose: Carrier between oscillator control and the clock multiplier
// Assumes: Ticks are one-cycle pulses on the block clock
// Notes:   Control comes from registers in the top module
interface iocm_mul_if;
   logic       enable;     // Multiplier enable bit
   logic       init;       // Multiplier initialise bit
   logic [1:0] sel;        // Input source select
   logic [2:0] scale;      // Output scaling code
   logic       int_tick;   // Internal oscillator tick
   logic       ext_tick;   // External oscillator rising edge
   logic       ready;      // Locked and producing output
   logic       out_tick;   // Multiplied clock tick
   modport ctrl (output enable, init, sel, scale, int_tick, ext_tick,
                 input  ready, out_tick);
   modport mult (input  enable, init, sel, scale, int_tick, ext_tick,
                 output ready, out_tick);
endinterface

// [hw/iocm_mult.sv]
// Purpose: Clock multiplier, four times input scaled by 2/k
// Assumes: Input ticks well below the block clock rate
// Notes:   Slow inputs give bursts of output ticks, then idle
module iocm_mult (
   input  wire logic clk_i,     // Block clock
   input  wire logic srst_i,    // Synchronous reset
   input  wire logic ce_i,      // Clock enable
   iocm_mul_if.mult  mul        // Control and ticks
);
   iocm_pkg::iocm_mul_state_type st_q, st_d;
   logic [2:0] lock_q, lock_d;
   logic [4:0] credit_q, credit_d;
   logic [1:0] gap_q, gap_d;
   logic       half_int_q, half_int_d, half_ext_q, half_ext_d;
   logic       out_q, out_d;
   logic       in_edge;
   logic [4:0] k;

   // Divisor k: factor 1 is 8/2, codes 1 to 6 give 2/2 to 2/7
   function automatic logic [4:0] scale_k(input logic [2:0] code);
      if (code == 3'h0) begin
         return 5'h02;
      end
      if (code == 3'h7) begin
         return 5'h07;   // Reserved code clamps to slowest
      end
      return {2'h0, code} + 5'h01;
   endfunction

   assign k = scale_k(mul.scale);

   // Input source choice and halving
   always_comb begin
      half_int_d = half_int_q ^ mul.int_tick;
      half_ext_d = half_ext_q ^ mul.ext_tick;
      unique case (mul.sel)
         iocm_pkg::MSEL_EXT:  in_edge = mul.ext_tick;
         iocm_pkg::MSEL_INT2: in_edge = mul.int_tick & half_int_q;
         iocm_pkg::MSEL_EXT2: in_edge = mul.ext_tick & half_ext_q;
         default:   in_edge = 1'b0;
      endcase
   end

   // Sequencing, lock counting and credit-based pulse emission
   always_comb begin
      st_d     = st_q;
      lock_d   = lock_q;
      credit_d = credit_q;
      gap_d    = (gap_q != 2'h0) ? gap_q - 2'h1 : 2'h0;
      out_d    = 1'b0;
      unique case (st_q)
         iocm_pkg::MUL_OFF: begin
            lock_d   = 3'h0;
            credit_d = 5'h00;
            if (mul.enable && mul.init) begin
               st_d = iocm_pkg::MUL_LOCKING;
            end
         end
         iocm_pkg::MUL_LOCKING: begin
            if (in_edge) begin
               lock_d = lock_q + 3'h1;
            end
            if (in_edge && lock_q == iocm_pkg::MUL_LOCK_EDGES - 3'h1) begin
               st_d = iocm_pkg::MUL_RUN;
            end
         end
         iocm_pkg::MUL_RUN: begin
            // Each input edge buys eight credits, each output costs k
            if (in_edge) begin
               credit_d = credit_q + iocm_pkg::MUL_CREDIT_EDGE;
               if (credit_q > iocm_pkg::MUL_CREDIT_MAX - iocm_pkg::MUL_CREDIT_EDGE) begin
                  credit_d = iocm_pkg::MUL_CREDIT_MAX; // Cap keeps bursts short
               end
            end
            if (credit_q >= k && gap_q == 2'h0) begin
               out_d    = 1'b1;
               credit_d = credit_d - k;
               gap_d    = iocm_pkg::MUL_PULSE_GAP;
            end
         end
      endcase
      if (!mul.enable || !mul.init) begin
         st_d = iocm_pkg::MUL_OFF;
      end
   end

   // State registers
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_q       <= iocm_pkg::MUL_OFF;
         lock_q     <= 3'h0;
         credit_q   <= 5'h00;
         gap_q      <= 2'h0;
         half_int_q <= 1'b0;
         half_ext_q <= 1'b0;
         out_q      <= 1'b0;
      end else if (ce_i) begin
         st_q       <= st_d;
         lock_q     <= lock_d;
         credit_q   <= credit_d;
         gap_q      <= gap_d;
         half_int_q <= half_int_d;
         half_ext_q <= half_ext_d;
         out_q      <= out_d;
      end
   end

   assign mul.ready    = (st_q == iocm_pkg::MUL_RUN);
   assign mul.out_tick = out_q & ce_i;

   chk_out_needs_ready: assert property (@(posedge clk_i) disable iff (srst_i)
      mul.out_tick |-> $past(st_q) == iocm_pkg::MUL_RUN)
      else $error("tick while unlocked");
   chk_pulse_spacing: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && out_q) |=> !out_q)
      else $error("output pulses adjacent");
endmodule

// [hw/iocm_pkg.sv]
// Purpose: Shared constants for the internal oscillator and clock multiplier
// Assumes: 8-bit special function register port, 10 MHz block clock
// Notes:   Oscillator periods are modelled as tick rates of the block clock
package iocm_pkg;
   // Register addresses
   localparam logic [7:0] ADDR_FINE   = 8'h9e;
   localparam logic [7:0] ADDR_CTRL   = 8'ha1;
   localparam logic [7:0] ADDR_COARSE = 8'ha2;
   localparam logic [7:0] ADDR_MULT   = 8'h97;
   localparam logic [7:0] ADDR_SRC    = 8'h8f;
   // Oscillator control fields and reset value
   localparam logic [7:0] CTRL_RESET  = 8'hd0;
   localparam int         CTRL_EN_HI  = 7;
   localparam int         CTRL_EN_LO  = 6;
   localparam int         CTRL_SUSP   = 5;
   localparam int         CTRL_RDY    = 4;
   localparam int         CTRL_RSVD   = 3;
   localparam logic [1:0] OSC_EN_OFF  = 2'h0;
   localparam logic [1:0] OSC_EN_ON   = 2'h3;
   localparam logic [2:0] DIV_RESET   = 3'h0;
   // Multiplier control fields
   localparam int         MULT_EN     = 7;
   localparam int         MULT_INIT   = 6;
   localparam int         MULT_RDY    = 5;
   localparam logic [1:0] MSEL_EXT    = 2'h0;
   localparam logic [1:0] MSEL_INT2   = 2'h1;
   localparam logic [1:0] MSEL_EXT2   = 2'h2;
   // System clock source codes
   localparam logic [1:0] SRC_INT     = 2'h0;
   localparam logic [1:0] SRC_EXT     = 2'h1;
   localparam logic [1:0] SRC_MULT    = 2'h2;
   // Counts
   localparam logic [2:0] OSC_SETTLE_TICKS = 3'h4;
   localparam logic [2:0] MUL_LOCK_EDGES   = 3'h4;
   localparam logic [4:0] MUL_CREDIT_EDGE  = 5'h08;
   localparam logic [4:0] MUL_CREDIT_MAX   = 5'h1f;
   localparam logic [1:0] MUL_PULSE_GAP    = 2'h1;
   // Multiplier sequencing
   typedef enum logic [1:0] {MUL_OFF, MUL_LOCKING, MUL_RUN} iocm_mul_state_type;
endpackage

// [hw/iocm_top.sv]
// Purpose: Internal oscillator control, divider, trims and clock multiplier
// Assumes: Register port is the core's special function register access
// Notes:   Read data follows the read address by one clock

module iocm_top #(
   parameter logic [6:0] FACTORY_COARSE = 7'h40,  // Per-part trim
   parameter logic [5:0] FACTORY_FINE   = 6'h20   // Per-part trim
) (
   input  wire logic       clk_i,        // 10 MHz block clock
   input  wire logic       srst_i,       // Synchronous reset
   input  wire logic       ce_i,         // Clock enable
   input  wire logic [7:0] sfr_addr_i,   // Register address
   input  wire logic       sfr_wr_i,     // Write strobe
   input  wire logic [7:0] sfr_wdata_i,  // Write data
   output logic      [7:0] sfr_rdata_o,  // Read data, one clock later
   input  wire logic [3:0] port_match_i, // Port 0..3 match events
   input  wire logic       cmp0_en_i,    // Comparator 0 enabled
   input  wire logic       cmp0_out_i,   // Comparator 0 output, async
   input  wire logic       ext_osc_i,    // External oscillator, async
   output logic            osc_tick_o,   // Internal oscillator tick
   output logic            system_clock_tick_o // System clock tick
);
   iocm_mul_if mul ();

   logic [1:0] en_q, en_d, src_q, src_d;
   logic       susp_q, susp_d;
   logic [2:0] div_q, div_d, div_act_q, div_act_d;
   logic [6:0] coarse_q, coarse_d, div_cnt_q, div_cnt_d;
   logic [5:0] fine_q, fine_d;
   logic [13:0] acc_q, acc_d;
   logic [2:0] settle_q, settle_d;
   logic [1:0] mctl_q, mctl_d;
   logic [1:0] msel_q, msel_d;
   logic [2:0] mscale_q, mscale_d;
   logic [7:0] rdata_d;
   logic [1:0] cmp_sync_q;
   logic [2:0] ext_sync_q;
   logic       running, osc_ready, osc_tick, wake, div_wrap, int_tick, ext_tick;
   logic [14:0] acc_sum;

   // Last count of divider for a code; 000 is /128, 111 is /1
   function automatic logic [6:0] div_last(input logic [2:0] code);
      return 7'(8'h80 >> code) - 7'h01;
   endfunction

   function automatic logic wr_hit(input logic [7:0] a);
      return sfr_wr_i && sfr_addr_i == a;
   endfunction

   // Pin synchronisers; third stage only feeds edge detection
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cmp_sync_q <= 2'h3;   // Idle high, so no false wake after reset
         ext_sync_q <= 3'h0;
      end else if (ce_i) begin
         cmp_sync_q <= {cmp_sync_q[0], cmp0_out_i};
         ext_sync_q <= {ext_sync_q[1:0], ext_osc_i};
      end
   end
   assign ext_tick = ext_sync_q[1] & ~ext_sync_q[2];

   // Wake on any port match or enabled comparator reading low
   assign wake    = (|port_match_i) | (cmp0_en_i & ~cmp_sync_q[1]);
   assign running = (en_q == iocm_pkg::OSC_EN_ON) && !susp_q;
   assign osc_ready = running && settle_q == iocm_pkg::OSC_SETTLE_TICKS;

   // Period model: step grows with trim, so 7f/3f runs fastest
   assign acc_sum  = {1'b0, acc_q} + {2'h0, coarse_q, fine_q} + 15'h0001;
   assign osc_tick = running & acc_sum[14] & ce_i;
   assign int_tick = osc_tick;
   assign div_wrap = osc_tick && div_cnt_q == div_last(div_act_q);

   // Register writes and oscillator state
   always_comb begin
      en_d     = en_q;
      susp_d   = susp_q;
      div_d    = div_q;
      coarse_d = coarse_q;
      fine_d   = fine_q;
      src_d    = src_q;
      mctl_d   = mctl_q;
      msel_d   = msel_q;
      mscale_d = mscale_q;
      if (susp_q && wake) begin
         susp_d = 1'b0;
      end
      if (wr_hit(iocm_pkg::ADDR_CTRL)) begin
         en_d = sfr_wdata_i[iocm_pkg::CTRL_EN_HI:iocm_pkg::CTRL_EN_LO];
         div_d = sfr_wdata_i[2:0];
         // Software set wins over a same-cycle wake
         if (sfr_wdata_i[iocm_pkg::CTRL_SUSP]) begin
            susp_d = 1'b1;
         end
      end
      if (wr_hit(iocm_pkg::ADDR_COARSE)) begin
         coarse_d = sfr_wdata_i[6:0];
      end
      if (wr_hit(iocm_pkg::ADDR_FINE)) begin
         fine_d = sfr_wdata_i[5:0];
      end
      if (wr_hit(iocm_pkg::ADDR_SRC)) begin
         src_d = sfr_wdata_i[1:0];
      end
      if (wr_hit(iocm_pkg::ADDR_MULT)) begin
         mctl_d   = sfr_wdata_i[iocm_pkg::MULT_EN:iocm_pkg::MULT_INIT];
         mscale_d = sfr_wdata_i[4:2];
         msel_d   = sfr_wdata_i[1:0];
      end
   end

   // Oscillator phase, settling and glitch-free divider
   always_comb begin
      acc_d     = running ? acc_sum[13:0] : 14'h0000;
      settle_d  = settle_q;
      div_cnt_d = div_cnt_q;
      div_act_d = div_act_q;
      if (!running) begin
         settle_d = 3'h0;
      end else if (osc_tick && settle_q != iocm_pkg::OSC_SETTLE_TICKS) begin
         settle_d = settle_q + 3'h1;
      end
      if (div_wrap) begin
         div_cnt_d = 7'h00;
         div_act_d = div_q;
      end else if (osc_tick) begin
         div_cnt_d = div_cnt_q + 7'h01;
      end
      if (!running) begin
         div_cnt_d = 7'h00;
         div_act_d = div_q;
      end
   end

   // Read mux; reserved and unused bits read zero
   always_comb begin
      unique case (sfr_addr_i)
         iocm_pkg::ADDR_CTRL:   rdata_d = {en_q, susp_q, osc_ready, 1'b0, div_q};
         iocm_pkg::ADDR_COARSE: rdata_d = {1'b0, coarse_q};
         iocm_pkg::ADDR_FINE:   rdata_d = {2'h0, fine_q};
         iocm_pkg::ADDR_SRC:    rdata_d = {6'h00, src_q};
         iocm_pkg::ADDR_MULT:   rdata_d = {mctl_q, mul.ready, mscale_q, msel_q};
         default:     rdata_d = 8'h00;
      endcase
   end

   // Registers; factory trims load at every reset
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         en_q        <= iocm_pkg::CTRL_RESET[iocm_pkg::CTRL_EN_HI:iocm_pkg::CTRL_EN_LO];
         susp_q      <= iocm_pkg::CTRL_RESET[iocm_pkg::CTRL_SUSP];
         div_q       <= iocm_pkg::DIV_RESET;
         div_act_q   <= iocm_pkg::DIV_RESET;
         div_cnt_q   <= 7'h00;
         coarse_q    <= FACTORY_COARSE;
         fine_q      <= FACTORY_FINE;
         acc_q       <= 14'h0000;
         settle_q    <= iocm_pkg::OSC_SETTLE_TICKS;
         src_q       <= iocm_pkg::SRC_INT;
         mctl_q      <= 2'h0;
         msel_q      <= iocm_pkg::MSEL_EXT;
         mscale_q    <= 3'h0;
         sfr_rdata_o <= 8'h00;
      end else if (ce_i) begin
         en_q        <= en_d;
         susp_q      <= susp_d;
         div_q       <= div_d;
         div_act_q   <= div_act_d;
         div_cnt_q   <= div_cnt_d;
         coarse_q    <= coarse_d;
         fine_q      <= fine_d;
         acc_q       <= acc_d;
         settle_q    <= settle_d;
         src_q       <= src_d;
         mctl_q      <= mctl_d;
         msel_q      <= msel_d;
         mscale_q    <= mscale_d;
         sfr_rdata_o <= rdata_d;
      end
   end

   // Multiplier hookup
   assign mul.enable   = mctl_q[1];
   assign mul.init     = mctl_q[0];
   assign mul.sel      = msel_q;
   assign mul.scale    = mscale_q;
   assign mul.int_tick = int_tick;
   assign mul.ext_tick = ext_tick & ce_i;

   iocm_mult u_mult (
      .clk_i  (clk_i),
      .srst_i (srst_i),
      .ce_i   (ce_i),
      .mul    (mul)
   );

   // System clock source; reserved code gives no ticks
   always_comb begin
      unique case (src_q)
         iocm_pkg::SRC_INT:  system_clock_tick_o = div_wrap;
         iocm_pkg::SRC_EXT:  system_clock_tick_o = mul.ext_tick;
         iocm_pkg::SRC_MULT: system_clock_tick_o = mul.out_tick;
         default:  system_clock_tick_o = 1'b0;
      endcase
   end
   assign osc_tick_o = osc_tick;

   chk_ctrl_rsvd_zero: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && sfr_addr_i == iocm_pkg::ADDR_CTRL) |=> sfr_rdata_o[iocm_pkg::CTRL_RSVD] == 1'b0)
      else $error("reserved bit read one");
   chk_off_no_tick: assert property (@(posedge clk_i) disable iff (srst_i)
      (en_q == iocm_pkg::OSC_EN_OFF) |-> !osc_tick_o)
      else $error("disabled oscillator ticks");
   chk_suspend_halts: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && wr_hit(iocm_pkg::ADDR_CTRL) && sfr_wdata_i[iocm_pkg::CTRL_SUSP])
      |=> !osc_tick_o && susp_q)
      else $error("suspend did not halt");
   chk_ready_running: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && sfr_addr_i == iocm_pkg::ADDR_CTRL && !running)
      |=> !sfr_rdata_o[iocm_pkg::CTRL_RDY])
      else $error("ready while stopped");
   chk_div_one: assert property (@(posedge clk_i) disable iff (srst_i)
      (src_q == iocm_pkg::SRC_INT && div_act_q == 3'h7) |-> system_clock_tick_o == osc_tick_o)
      else $error("divide by one wrong");
   chk_trim_top_zero: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && sfr_addr_i == iocm_pkg::ADDR_FINE) |=> sfr_rdata_o[7:6] == 2'h0)
      else $error("unused trim bits set");
   chk_wake_resumes: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && susp_q && wake && !wr_hit(iocm_pkg::ADDR_CTRL)) |=> !susp_q)
      else $error("wake ignored");
   chk_div_boundary: assert property (@(posedge clk_i) disable iff (srst_i)
      (running && $past(running) && div_act_q != $past(div_act_q)) |-> $past(div_wrap))
      else $error("divider switched mid-period");
   chk_mult_source: assert property (@(posedge clk_i) disable iff (srst_i)
      (src_q == iocm_pkg::SRC_MULT) |-> system_clock_tick_o == mul.out_tick)
      else $error("multiplier not selected");
endmodule
